// file: pkg/seq_pkg.sv
package seq_pkg;
   // core geometry
   localparam int PC_W     = 10;
   localparam int DA_W     = 7;
   localparam int DW       = 8;
   localparam int IW       = 16;
   localparam int STK_D    = 4;
   localparam int STK_W    = 2;
   localparam int BIT_W    = 3;
   // system clocks in one instruction cycle
   localparam int CYC_CLKS = 4;
   localparam int PH_W     = $clog2(CYC_CLKS);
   localparam logic [PH_W-1:0] PH_FIRST = PH_W'(0);
   localparam logic [PH_W-1:0] PH_STEP  = PH_W'(1);
   localparam logic [PH_W-1:0] PH_EXEC  = PH_W'(CYC_CLKS - 2);
   localparam logic [PH_W-1:0] PH_LAST  = PH_W'(CYC_CLKS - 1);
   // fixed addresses, steps and byte constants
   localparam logic [PC_W-1:0] RST_VEC  = 10'h000;
   localparam logic [PC_W-1:0] INT_VEC  = 10'h004;
   localparam logic [PC_W-1:0] PC_STEP  = 10'h001;
   localparam logic [DA_W-1:0] PROGRAM_COUNTER_LOW_ADDR = 7'h06;
   localparam logic [STK_W-1:0] SP_STEP = 2'h1;
   localparam logic [DW-1:0]   BYTE_ONE = 8'h01;
   localparam logic [DW-1:0]   BYTE_MAX = 8'hFF;

   // instruction word: op in [15:10], bit select [9:7], address [6:0]
   typedef enum logic [5:0] {
      nop_op, mov_am_op, mov_ma_op, mov_ax_op,
      add_am_op, addm_op, add_ax_op, adc_am_op,
      sub_am_op, subm_op, sub_ax_op, sbc_am_op,
      and_am_op, or_am_op, xor_am_op, andm_op,
      and_ax_op, or_ax_op, xor_ax_op, cpl_op, cpla_op, clr_op,
      inc_op, inca_op, dec_op, deca_op,
      rr_op, rl_op, rrc_op, rlc_op,
      skip_zero_op, skip_bit_clear_op, skip_bit_set_op,
      unconditional_jump_op, call_op, subroutine_return_op,
      return_from_interrupt_op, table_read_op,
      int_enable_op, int_disable_op
   } op_t;

   typedef struct packed {
      op_t              op;
      logic [BIT_W-1:0] bsel;
      logic [DA_W-1:0]  addr;
   } instr_t;

   typedef struct packed {
      logic [DW-1:0] res;
      logic          c;
      logic          z;
      logic          c_upd;
      logic          z_upd;
      logic          to_acc;
      logic          to_mem;
   } alu_res_t;

   typedef struct packed {
      logic [DA_W-1:0] addr;
      logic [DW-1:0]   wdata;
      logic            we;
   } dm_req_t;

   typedef struct packed {
      logic z;
      logic c;
      logic global_interrupt_enable;
   } status_t;

   typedef struct packed {
      logic [PH_W-1:0]             ph;
      logic [PC_W-1:0]             pc;
      logic [PC_W-1:0]             pma;
      logic [PC_W-1:0]             tgt;
      instr_t                      ir;
      logic                        irv;
      logic                        flush;
      logic                        tbl;
      logic                        ack;
      logic [DW-1:0]               acc;
      logic [DW-1:0]               wdata;
      logic [DA_W-1:0]             dma;
      logic                        we;
      status_t                     st;
      logic [STK_W-1:0]            sp;
      logic [STK_D-1:0][PC_W-1:0]  stk;
   } core_t;

   localparam core_t CORE_RST = '{
      ph: PH_FIRST, pc: RST_VEC, pma: RST_VEC, tgt: RST_VEC,
      ir: '{op: nop_op, bsel: 3'h0, addr: 7'h00},
      irv: 1'b0, flush: 1'b0, tbl: 1'b0, ack: 1'b0,
      acc: 8'h00, wdata: 8'h00, dma: 7'h00, we: 1'b0,
      st: '{z: 1'b0, c: 1'b0, global_interrupt_enable: 1'b0},
      sp: 2'h0, stk: '0
   };
endpackage : seq_pkg

// file: hw/core_alu.sv
`timescale 1ns/100ps
module core_alu (
   input  wire logic [5:0]        op,
   input  wire logic [7:0]        acc,
   input  wire logic [7:0]        mval,
   input  wire logic [7:0]        imm,
   input  wire logic              cin,
   output seq_pkg::alu_res_t      res
);
   import seq_pkg::*;
   logic [8:0] w;
   op_t        o;

   assign o = op_t'(op);

   // data path: result, carry or borrow, zero, destination
   always_comb begin
      w = 9'h000;
      res = '0;
      case (o)
         mov_am_op: begin res.res = mval; res.to_acc = 1'b1; end
         mov_ma_op: begin res.res = acc; res.to_mem = 1'b1; end
         mov_ax_op: begin res.res = imm; res.to_acc = 1'b1; end
         add_am_op, addm_op, add_ax_op, adc_am_op: begin
            w = {1'b0, acc} + {1'b0, (o == add_ax_op) ? imm : mval}
                + {8'h00, (o == adc_am_op) & cin};
            res.c_upd = 1'b1;
            res.to_mem = (o == addm_op);
         end
         sub_am_op, subm_op, sub_ax_op, sbc_am_op: begin
            // bit 8 of the difference is the borrow
            w = {1'b0, acc} - {1'b0, (o == sub_ax_op) ? imm : mval}
                - {8'h00, (o == sbc_am_op) & cin};
            res.c_upd = 1'b1;
            res.to_mem = (o == subm_op);
         end
         and_am_op, andm_op: w = {1'b0, acc & mval};
         or_am_op:  w = {1'b0, acc | mval};
         xor_am_op: w = {1'b0, acc ^ mval};
         and_ax_op: w = {1'b0, acc & imm};
         or_ax_op:  w = {1'b0, acc | imm};
         xor_ax_op: w = {1'b0, acc ^ imm};
         cpl_op, cpla_op: w = {1'b0, ~mval};
         clr_op: begin res.res = 8'h00; res.to_mem = 1'b1; end
         inc_op, inca_op: w = {1'b0, mval + BYTE_ONE};
         dec_op, deca_op: w = {1'b0, mval - BYTE_ONE};
         rr_op:  begin res.res = {mval[0], mval[7:1]}; res.to_mem = 1'b1; end
         rl_op:  begin res.res = {mval[6:0], mval[7]}; res.to_mem = 1'b1; end
         rrc_op: begin
            res.res = {cin, mval[7:1]};
            res.c = mval[0];
            res.c_upd = 1'b1;
            res.to_mem = 1'b1;
         end
         rlc_op: begin
            res.res = {mval[6:0], cin};
            res.c = mval[7];
            res.c_upd = 1'b1;
            res.to_mem = 1'b1;
         end
         default: res.res = 8'h00;
      endcase
      // arithmetic and logic groups take the result from the wide sum
      if (w != 9'h000 || res.c_upd && !res.to_mem && o != rrc_op ||
          o inside {add_am_op, addm_op, add_ax_op, adc_am_op, sub_am_op,
                    subm_op, sub_ax_op, sbc_am_op, and_am_op, andm_op,
                    or_am_op, xor_am_op, and_ax_op, or_ax_op, xor_ax_op,
                    cpl_op, cpla_op, inc_op, inca_op, dec_op, deca_op})
      begin
         res.res = w[7:0];
         res.z_upd = 1'b1;
         if (o inside {add_am_op, addm_op, add_ax_op, adc_am_op,
                       sub_am_op, subm_op, sub_ax_op, sbc_am_op})
            res.c = w[8];
         res.to_acc = !(o inside {addm_op, subm_op, andm_op, cpl_op,
                                  inc_op, dec_op});
         res.to_mem = !res.to_acc;
      end
      res.z = (res.res == 8'h00);
   end
endmodule : core_alu

// file: hw/instruction_sequencer.sv
// Function
// - four system clocks per instruction cycle; fetch and execute per cycle
// - most instructions take one cycle; branch, call, table read take two
// - jump, call, return and interrupt return add one cycle
// - writing the program counter low byte is a jump with one extra cycle
// - a skip that skips costs one extra cycle, otherwise one cycle
// - addition flags carry above 255, subtraction flags borrow below zero
// - increment and decrement by one, to memory or to accumulator
// - logic and complement results set zero flag when result is zero
// - rotates move one bit; through-carry forms move outgoing bit to carry
// - moves: memory to accumulator, accumulator to memory, constant in
// - call saves the following address; return resumes there
// - jump loads the target and saves nothing
// - conditional skips test a byte or a bit and skip the next op
// - interrupt return sets the interrupt enable; plain return keeps it
// - interrupt entry pushes only the program counter
`timescale 1ns/100ps
module instruction_sequencer (
   input  wire logic                      mclk,
   input  wire logic                      rstn,
   output logic [seq_pkg::PC_W-1:0]       pm_addr,
   input  wire logic [seq_pkg::IW-1:0]    pm_data,
   output seq_pkg::dm_req_t               dm_req,
   input  wire logic [seq_pkg::DW-1:0]    dm_rdata,
   input  wire logic                      irq,
   output logic                           irq_ack,
   output logic [seq_pkg::DW-1:0]         acc,
   output seq_pkg::status_t               status
);
   import seq_pkg::*;

   // assertions below all run on the system clock
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rstn);

   core_t            s;
   core_t            next_s;
   alu_res_t         a;
   instr_t           fetched;
   logic [PC_W-1:0]  cur_pc;
   logic [PC_W-1:0]  seq_pc;
   logic [STK_W-1:0] sp_dn;
   logic [DW-1:0]    mval;
   logic             is_pc_low;
   logic             int_take;

   // operand view: the low program counter byte lives here, not in memory
   assign fetched = instr_t'(pm_data);
   assign cur_pc  = s.pc - PC_STEP;
   assign seq_pc  = s.pc + PC_STEP;
   assign sp_dn   = s.sp - SP_STEP;
   assign is_pc_low = (s.ir.addr == PROGRAM_COUNTER_LOW_ADDR);
   assign mval    = is_pc_low ? cur_pc[7:0] : dm_rdata;
   assign int_take = irq && s.st.global_interrupt_enable;

   core_alu u_alu (
      .op   (s.ir.op),
      .acc  (s.acc),
      .mval (mval),
      .imm  ({s.ir.bsel[0], s.ir.addr}),
      .cin  (s.st.c),
      .res  (a)
   );

   // next state: execute at the third clock, sequence at the fourth
   always_comb begin
      next_s = s;
      next_s.ack = 1'b0;
      next_s.ph = (s.ph == PH_LAST) ? PH_FIRST : s.ph + PH_STEP;
      if (s.ph == PH_EXEC) begin
         if (s.irv) begin
            if (a.to_acc)
               next_s.acc = a.res;
            if (a.c_upd)
               next_s.st.c = a.c;
            if (a.z_upd)
               next_s.st.z = a.z;
            if (a.to_mem && is_pc_low) begin
               // a write to the low pc byte redirects the fetch
               next_s.flush = 1'b1;
               next_s.tgt = {s.pc[PC_W-1:8], a.res};
            end else if (a.to_mem) begin
               next_s.wdata = a.res;
               next_s.we = 1'b1;
            end
            case (s.ir.op)
               unconditional_jump_op: begin
                  next_s.flush = 1'b1;
                  next_s.tgt = {s.ir.bsel, s.ir.addr};
               end
               call_op: begin
                  // s.pc already holds the address after the call
                  next_s.stk[s.sp] = s.pc;
                  next_s.sp = s.sp + SP_STEP;
                  next_s.flush = 1'b1;
                  next_s.tgt = {s.ir.bsel, s.ir.addr};
               end
               subroutine_return_op: begin
                  next_s.sp = sp_dn;
                  next_s.tgt = s.stk[sp_dn];
                  next_s.flush = 1'b1;
               end
               return_from_interrupt_op: begin
                  next_s.sp = sp_dn;
                  next_s.tgt = s.stk[sp_dn];
                  next_s.flush = 1'b1;
                  next_s.st.global_interrupt_enable = 1'b1;
               end
               skip_zero_op: begin
                  next_s.flush = (mval == 8'h00);
                  next_s.tgt = seq_pc;
               end
               skip_bit_clear_op: begin
                  next_s.flush = !mval[s.ir.bsel];
                  next_s.tgt = seq_pc;
               end
               skip_bit_set_op: begin
                  next_s.flush = mval[s.ir.bsel];
                  next_s.tgt = seq_pc;
               end
               table_read_op: begin
                  // the second cycle fetches the table word, then resumes
                  next_s.flush = 1'b1;
                  next_s.tgt = s.pc;
                  next_s.tbl = 1'b1;
               end
               int_enable_op:
                  next_s.st.global_interrupt_enable = 1'b1;
               int_disable_op:
                  next_s.st.global_interrupt_enable = 1'b0;
               default: ;
            endcase
            // interrupts enter only at a plain instruction boundary
            if (!next_s.flush && int_take) begin
               next_s.stk[s.sp] = s.pc;
               next_s.sp = s.sp + SP_STEP;
               next_s.flush = 1'b1;
               next_s.tgt = INT_VEC;
               next_s.st.global_interrupt_enable = 1'b0;
               next_s.ack = 1'b1;
            end
         end else if (s.tbl) begin
            // low byte of the table word lands in memory, fetch returns to the program
            next_s.wdata = pm_data[7:0];
            next_s.we = 1'b1;
            next_s.tbl = 1'b0;
            next_s.pma = s.pc;
         end
      end else if (s.ph == PH_LAST) begin
         next_s.we = 1'b0;
         next_s.flush = 1'b0;
         next_s.ir = fetched;
         next_s.irv = !s.flush;
         next_s.pc = s.flush ? s.tgt : seq_pc;
         next_s.pma = s.tbl ? {s.pc[PC_W-1:8], s.acc} : next_s.pc;
         next_s.dma = s.tbl ? s.dma : fetched.addr;
      end
   end

   // state register
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn)
         s <= CORE_RST;
      else
         s <= next_s;
   end

   // outputs straight from the state register
   assign pm_addr      = s.pma;
   assign dm_req.addr  = s.dma;
   assign dm_req.wdata = s.wdata;
   assign dm_req.we    = s.we;
   assign irq_ack      = s.ack;
   assign acc          = s.acc;
   assign status       = s.st;

   // checks on sequencing and data path
   logic exec;
   assign exec = (s.ph == PH_EXEC) && s.irv;

   phase_wrap_a: assert property (
      s.ph == PH_FIRST |=> s.ph == 2'h1 ##1 s.ph == 2'h2
         ##1 s.ph == 2'h3 ##1 s.ph == PH_FIRST)
      else $error("instruction cycle is not four clocks");

   single_cycle_a: assert property (
      exec && s.ir.op == mov_ax_op && !int_take
         |=> !s.flush ##2 s.irv)
      else $error("plain move took an extra cycle");

   jump_extra_a: assert property (
      exec && s.ir.op == unconditional_jump_op
         |=> s.flush && s.sp == $past(s.sp)
         ##1 !s.irv && s.pc == $past(s.tgt))
      else $error("jump did not redirect with one bubble");

   pc_low_write_a: assert property (
      exec && a.to_mem && is_pc_low
         |=> s.flush && !s.we && s.tgt[7:0] == $past(a.res))
      else $error("low pc write not treated as a jump");

   skip_taken_a: assert property (
      exec && s.ir.op == skip_zero_op && mval == 8'h00
         |=> s.flush && s.tgt == $past(seq_pc) ##1 !s.irv)
      else $error("taken skip did not cost one cycle");

   skip_bit_a: assert property (
      exec && s.ir.op == skip_bit_set_op && !mval[s.ir.bsel] && !int_take
         |=> !s.flush)
      else $error("untaken bit skip flushed");

   add_carry_a: assert property (
      exec && s.ir.op == add_am_op
         |=> s.st.c == ({1'b0, $past(s.acc)} + {1'b0, $past(mval)}
                        > 9'h0FF))
      else $error("add carry wrong");

   sub_borrow_a: assert property (
      exec && s.ir.op == sub_am_op
         |=> s.st.c == ($past(s.acc) < $past(mval)))
      else $error("subtract borrow wrong");

   inc_acc_a: assert property (
      exec && s.ir.op == inca_op |=> s.acc == $past(mval) + BYTE_ONE)
      else $error("increment to accumulator wrong");

   dec_mem_a: assert property (
      exec && s.ir.op == dec_op && !is_pc_low
         |=> s.we && s.wdata == $past(mval) - BYTE_ONE)
      else $error("decrement to memory wrong");

   logic_zero_a: assert property (
      exec && s.ir.op inside {and_am_op, or_am_op, xor_am_op, cpla_op}
         |=> s.st.z == (s.acc == 8'h00))
      else $error("logic zero flag wrong");

   rot_carry_a: assert property (
      exec && s.ir.op == rrc_op && !is_pc_low
         |=> {s.wdata, s.st.c} == {$past(s.st.c), $past(mval)})
      else $error("rotate through carry wrong");

   move_store_a: assert property (
      exec && s.ir.op == mov_ma_op && !is_pc_low
         |=> s.we && s.wdata == $past(s.acc) && s.acc == $past(s.acc))
      else $error("accumulator store wrong");

   call_push_a: assert property (
      exec && s.ir.op == call_op
         |=> s.sp == $past(s.sp) + SP_STEP
         && s.stk[$past(s.sp)] == $past(s.pc))
      else $error("call did not save return address");

   irq_return_a: assert property (
      exec && s.ir.op == return_from_interrupt_op
         |=> s.st.global_interrupt_enable)
      else $error("interrupt return left enable low");

   return_keep_a: assert property (
      exec && s.ir.op == subroutine_return_op
         |=> $stable(s.st.global_interrupt_enable))
      else $error("plain return changed enable");

   int_entry_a: assert property (
      s.ack |-> s.flush && s.tgt == INT_VEC
         && s.stk[$past(s.sp)] == $past(s.pc)
         && !s.st.global_interrupt_enable)
      else $error("interrupt entry push wrong");

   flush_drop_a: assert property (
      s.ph == PH_LAST && s.flush && !s.tbl
         |=> !s.irv && s.pc == $past(s.tgt) && s.pma == s.pc)
      else $error("prefetched op not discarded");
endmodule : instruction_sequencer

// file: bench/core_memory_model.sv
`timescale 1ns/100ps
module core_memory_model (
   input  wire logic                     mclk,
   input  wire logic [seq_pkg::PC_W-1:0] pm_addr,
   output logic [seq_pkg::IW-1:0]        pm_data,
   input  wire seq_pkg::dm_req_t         dm_req,
   output logic [seq_pkg::DW-1:0]        dm_rdata
);
   import seq_pkg::*;

   logic [IW-1:0] prog [0:(1<<PC_W)-1];
   logic [DW-1:0] dmem [0:(1<<DA_W)-1];

   // asynchronous reads of program and data memory
   assign pm_data  = prog[pm_addr];
   assign dm_rdata = dmem[dm_req.addr];

   // data write lands on the edge that ends the strobe
   always @(posedge mclk) begin
      if (dm_req.we === 1'h1) begin
         dmem[dm_req.addr] <= dm_req.wdata;
      end
   end
endmodule : core_memory_model

// file: bench/mcu_instruction_sequencer_tb.sv
`timescale 1ns/100ps
module mcu_instruction_sequencer_tb;
   import seq_pkg::*;

   typedef struct packed {
      logic [7:0] a;
      op_t        op;
      logic [7:0] f;
      logic [7:0] m;
      logic [7:0] ea;
      logic [7:0] em;
      logic       c;
      logic       z;
   } alu_case_t;

   // acc start, op, field, mem start, acc, mem, carry, zero
   localparam alu_case_t ALU_TBL [27] = '{
      '{8'hF0, add_ax_op, 8'h20, 8'h00, 8'h10, 8'h00, 1'h1, 1'h0},
      '{8'h01, add_am_op, 8'h10, 8'h0F, 8'h10, 8'h0F, 1'h0, 1'h0},
      '{8'h80, addm_op,   8'h10, 8'h80, 8'h80, 8'h00, 1'h1, 1'h1},
      '{8'h10, sub_ax_op, 8'h20, 8'h00, 8'hF0, 8'h00, 1'h1, 1'h0},
      '{8'h05, sub_am_op, 8'h10, 8'h05, 8'h00, 8'h05, 1'h0, 1'h1},
      '{8'h00, subm_op,   8'h10, 8'h01, 8'h00, 8'hFF, 1'h1, 1'h0},
      '{8'h11, inc_op,    8'h10, 8'hFF, 8'h11, 8'h00, 1'h0, 1'h1},
      '{8'h11, inca_op,   8'h10, 8'h7F, 8'h80, 8'h7F, 1'h0, 1'h0},
      '{8'h11, dec_op,    8'h10, 8'h01, 8'h11, 8'h00, 1'h0, 1'h1},
      '{8'h11, deca_op,   8'h10, 8'h00, 8'hFF, 8'h00, 1'h0, 1'h0},
      '{8'hF0, and_am_op, 8'h10, 8'h0F, 8'h00, 8'h0F, 1'h0, 1'h1},
      '{8'h00, or_ax_op,  8'h00, 8'h00, 8'h00, 8'h00, 1'h0, 1'h1},
      '{8'h5A, xor_am_op, 8'h10, 8'h5A, 8'h00, 8'h5A, 1'h0, 1'h1},
      '{8'h11, cpl_op,    8'h10, 8'hFF, 8'h11, 8'h00, 1'h0, 1'h1},
      '{8'h11, cpla_op,   8'h10, 8'h0F, 8'hF0, 8'h0F, 1'h0, 1'h0},
      '{8'h11, rlc_op,    8'h10, 8'h81, 8'h11, 8'h02, 1'h1, 1'h0},
      '{8'h11, rrc_op,    8'h10, 8'h01, 8'h11, 8'h00, 1'h1, 1'h0},
      '{8'h11, rl_op,     8'h10, 8'h81, 8'h11, 8'h03, 1'h0, 1'h0},
      '{8'h11, rr_op,     8'h10, 8'h01, 8'h11, 8'h80, 1'h0, 1'h0},
      '{8'h11, mov_am_op, 8'h10, 8'h3C, 8'h3C, 8'h3C, 1'h0, 1'h0},
      '{8'hA5, mov_ma_op, 8'h10, 8'h00, 8'hA5, 8'hA5, 1'h0, 1'h0},
      '{8'hF0, adc_am_op, 8'h10, 8'h10, 8'h00, 8'h10, 1'h1, 1'h1},
      '{8'h05, sbc_am_op, 8'h10, 8'h06, 8'hFF, 8'h06, 1'h1, 1'h0},
      '{8'hF0, andm_op,   8'h10, 8'h3C, 8'hF0, 8'h30, 1'h0, 1'h0},
      '{8'hF0, and_ax_op, 8'h0F, 8'h00, 8'h00, 8'h00, 1'h0, 1'h1},
      '{8'h5A, xor_ax_op, 8'hFF, 8'h00, 8'hA5, 8'h00, 1'h0, 1'h0},
      '{8'h11, clr_op,    8'h10, 8'h77, 8'h11, 8'h00, 1'h0, 1'h0}
   };

   logic            mclk;
   logic            rstn;
   logic            irq;
   logic [PC_W-1:0] pm_addr;
   logic [IW-1:0]   pm_data;
   dm_req_t         dm_req;
   logic [DW-1:0]   dm_rdata;
   logic            irq_ack;
   logic [DW-1:0]   acc;
   status_t         status;
   int              failures;
   int              samples_checked;

   instruction_sequencer i_instruction_sequencer (
      .mclk     (mclk),
      .rstn     (rstn),
      .pm_addr  (pm_addr),
      .pm_data  (pm_data),
      .dm_req   (dm_req),
      .dm_rdata (dm_rdata),
      .irq      (irq),
      .irq_ack  (irq_ack),
      .acc      (acc),
      .status   (status)
   );

   core_memory_model i_core_memory_model (
      .mclk     (mclk),
      .pm_addr  (pm_addr),
      .pm_data  (pm_data),
      .dm_req   (dm_req),
      .dm_rdata (dm_rdata)
   );

   // 50 MHz system clock
   initial begin
      mclk = 1'h0;
      forever #10 mclk = ~mclk;
   end

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         failures++;
         $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
      end
   endtask : check

   // counts clocks until the fetch address shows up
   task automatic wait_addr(input logic [PC_W-1:0] a, output int n);
      n = 0;
      while (pm_addr !== a && n < 400) begin
         @(negedge mclk);
         n++;
      end
      if (pm_addr !== a) begin
         check(16'(pm_addr), 16'(a));
      end
   endtask : wait_addr

   task automatic put(input logic [PC_W-1:0] a, input op_t op,
                      input logic [9:0] f);
      i_core_memory_model.prog[a] = {op, f};
   endtask : put

   // blank memories, then the caller loads its program
   task automatic clear_mem;
      for (int i = 0; i < (1 << PC_W); i++) begin
         put(PC_W'(i), nop_op, 10'h000);
      end
      for (int i = 0; i < (1 << DA_W); i++) begin
         i_core_memory_model.dmem[i] = 8'h00;
      end
   endtask : clear_mem

   task automatic restart;
      rstn = 1'h0;
      irq  = 1'h0;
      repeat (2) @(negedge mclk);
      rstn = 1'h1;
   endtask : restart

   // one load, one operation, then a self loop
   task automatic test_alu;
      int n;
      foreach (ALU_TBL[i]) begin
         clear_mem;
         put(10'h000, mov_ax_op, {2'h0, ALU_TBL[i].a});
         put(10'h001, ALU_TBL[i].op, {2'h0, ALU_TBL[i].f});
         put(10'h002, unconditional_jump_op, 10'h002);
         i_core_memory_model.dmem[16] = ALU_TBL[i].m;
         restart;
         wait_addr(10'h001, n);
         wait_addr(10'h003, n);
         check(16'(acc), 16'(ALU_TBL[i].ea));
         check(16'(i_core_memory_model.dmem[16]),
               16'(ALU_TBL[i].em));
         check(16'(status.c), 16'(ALU_TBL[i].c));
         check(16'(status.z), 16'(ALU_TBL[i].z));
      end
   endtask : test_alu

   // jump, call, return, taken and untaken skip in one walk
   task automatic test_timing;
      int n;
      clear_mem;
      put(10'h001, unconditional_jump_op, 10'h010);
      put(10'h010, call_op, 10'h020);
      put(10'h020, subroutine_return_op, 10'h000);
      put(10'h011, skip_zero_op, 10'h010);
      put(10'h012, unconditional_jump_op, 10'h012);
      put(10'h013, skip_zero_op, 10'h011);
      put(10'h014, unconditional_jump_op, 10'h014);
      i_core_memory_model.dmem[17] = 8'h01;
      restart;
      wait_addr(10'h001, n);
      wait_addr(10'h014, n);
      check(16'(n), 16'h0024);
      // untaken skip costs one cycle, then the loop jump runs
      wait_addr(10'h015, n);
      check(16'(n), 16'h0004);
      wait_addr(10'h014, n);
      check(16'(n), 16'h0004);
   endtask : test_timing

   // enable switched on, bit skips both ways, then the enable is switched off
   task automatic test_bit_skip;
      int n;
      clear_mem;
      put(10'h000, int_enable_op, 10'h000);
      put(10'h001, skip_bit_set_op, 10'h111);
      put(10'h002, unconditional_jump_op, 10'h002);
      put(10'h003, skip_bit_clear_op, 10'h111);
      put(10'h004, unconditional_jump_op, 10'h008);
      put(10'h008, skip_bit_clear_op, 10'h011);
      put(10'h009, unconditional_jump_op, 10'h009);
      put(10'h00A, int_disable_op, 10'h000);
      put(10'h00C, unconditional_jump_op, 10'h00C);
      i_core_memory_model.dmem[17] = 8'h04;
      restart;
      wait_addr(10'h001, n);
      wait_addr(10'h00B, n);
      check(16'(n), 16'h0020);
      check(16'(status.global_interrupt_enable), 16'h0001);
      wait_addr(10'h00C, n);
      check(16'(n), 16'h0004);
      check(16'(status.global_interrupt_enable), 16'h0000);
   endtask : test_bit_skip

   // a write to the low pc byte jumps and is not stored
   task automatic test_low_pc;
      int n;
      clear_mem;
      put(10'h000, mov_ax_op, 10'h020);
      put(10'h001, mov_ma_op, 10'h006);
      put(10'h002, unconditional_jump_op, 10'h002);
      put(10'h020, unconditional_jump_op, 10'h020);
      restart;
      wait_addr(10'h001, n);
      wait_addr(10'h021, n);
      check(16'(n), 16'h000C);
      check(16'(i_core_memory_model.dmem[6]), 16'h0000);
   endtask : test_low_pc

   task automatic test_table_read;
      int n;
      clear_mem;
      put(10'h000, mov_ax_op, 10'h030);
      put(10'h001, table_read_op, 10'h010);
      put(10'h002, unconditional_jump_op, 10'h002);
      i_core_memory_model.prog[48] = 16'h12AB;
      restart;
      wait_addr(10'h001, n);
      wait_addr(10'h003, n);
      check(16'(n), 16'h000C);
      check(16'(i_core_memory_model.dmem[16]), 16'h00AB);
   endtask : test_table_read

   // plain return keeps the enable low, interrupt return sets it
   task automatic test_interrupt;
      int n;
      for (int v = 0; v < 2; v++) begin
         clear_mem;
         put(10'h000, unconditional_jump_op, 10'h008);
         put(10'h004, v ? return_from_interrupt_op : subroutine_return_op,
             10'h000);
         put(10'h008, int_enable_op, 10'h000);
         put(10'h00C, unconditional_jump_op, 10'h00C);
         restart;
         n = 0;
         while (status.global_interrupt_enable !== 1'h1 && n < 100) begin
            @(negedge mclk);
            n++;
         end
         irq = 1'h1;
         n = 0;
         while (irq_ack !== 1'h1 && n < 100) begin
            @(negedge mclk);
            n++;
         end
         irq = 1'h0;
         check(16'(irq_ack), 16'h0001);
         check(16'(status.global_interrupt_enable), 16'h0000);
         wait_addr(10'h005, n);
         wait_addr(10'h00D, n);
         check(16'(status.global_interrupt_enable), 16'(v));
      end
   endtask : test_interrupt

   task automatic complete_run;
      $display("failures=%0d samples_checked=%0d", failures, samples_checked);
      if (failures == 0 && samples_checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : complete_run

   // main sequence
   initial begin
      rstn = 1'h0;
      irq = 1'h0;
      failures = 0;
      samples_checked = 0;
      test_timing;
      test_bit_skip;
      test_low_pc;
      test_table_read;
      test_alu;
      test_interrupt;
      complete_run;
   end

   // hang guard, well beyond the expected run
   initial begin
      #200000;
      failures++;
      complete_run;
   end
endmodule : mcu_instruction_sequencer_tb
